/* File: hdl/vfc_i2c_slave.v */
// Serial command slave of a triple-channel video filter: bus engine and command interpreter.
// What this block does and what it expects of the bus master
// RULE_01: Detect START and STOP while clock high.
// RULE_02: After STOP or mismatch, ignore until START.
// RULE_03: STOP anywhere aborts, discarding partial data.
// RULE_04: Master separates START and STOP by clock.
// RULE_05: Back-to-back writes with or without repeated START.
// RULE_06: Ninth pulse: receiver pulls low to acknowledge.
// RULE_07: Master retries after a not-acknowledge.
// RULE_08: Acknowledge matching address and every data byte.
// RULE_09: Release data line on ninth pulse of read.
// RULE_10: Compare address serially; drop out on mismatch.
// RULE_11: Address is 10010 plus two select pins.
// RULE_12: Master holds select pins stable while sampled.
// RULE_13: Eighth address bit selects write or read.
// RULE_14: First byte after write address is command.
// RULE_15: Aborted write leaves target register unchanged.
// RULE_16: Code zero powers down, one wakes.
// RULE_17: Codes two to seven set clamp levels.
// RULE_18: Eight component, nine composite input.
// RULE_19: Ten/eleven sync source, twelve/thirteen polarity.
// RULE_20: Fourteen enables filters, fifteen bypasses.
// RULE_21: Sixteen restores status, keeps frequency.
// RULE_22: Seventeen/nineteen arm status or frequency read.
// RULE_23: Eighteen stores next data byte as frequency.
// RULE_24: Read sends exactly one byte of armed register.
// RULE_25: Status register powers on at default.
// RULE_26: No general call, no ten-bit addressing.
// RULE_27: Unknown commands acknowledged, change nothing.
`include "vfc_map.vh"
module vfc_i2c_slave (
  ref_clk,
  rstn,
  scl_in,
  sda_in,
  sda_out,
  sda_oe_n,
  addr_select_pin_high,
  addr_select_pin_low,
  status_out,
  freq_out
);
  input  wire       ref_clk;
  input  wire       rstn;
  input  wire       scl_in;
  input  wire       sda_in;
  output wire       sda_out;
  output reg        sda_oe_n;
  input  wire       addr_select_pin_high;
  input  wire       addr_select_pin_low;
  output reg  [7:0] status_out;
  output reg  [7:0] freq_out;

  // Bus engine states.
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_AACK = 3'h2;
  localparam [2:0] ST_RXD  = 3'h3;
  localparam [2:0] ST_DACK = 3'h4;
  localparam [2:0] ST_TXD  = 3'h5;
  localparam [2:0] ST_TACK = 3'h6;

  // Meaning of the next received byte within a write cycle.
  localparam [1:0] NXT_CMD  = 2'h0;
  localparam [1:0] NXT_FREQ = 2'h1;
  localparam [1:0] NXT_NONE = 2'h2;

  wire scl_lvl;
  wire scl_rise;
  wire scl_fall;
  wire sda_lvl;
  wire sda_rise;
  wire sda_fall;

  reg  [1:0] sel_meta_reg;
  reg  [1:0] sel_sync_reg;

  reg  [2:0] state_reg;
  reg  [3:0] bit_cnt_reg;
  reg  [7:0] shift_reg;
  reg        read_dir_reg;
  reg  [1:0] nxt_reg;
  reg        rd_freq_reg;
  reg        drive_low_reg;

  vfc_line_sync u_scl_sync (
    .ref_clk    (ref_clk),
    .rstn       (rstn),
    .line_in    (scl_in),
    .line_level (scl_lvl),
    .line_rise  (scl_rise),
    .line_fall  (scl_fall)
  );

  vfc_line_sync u_sda_sync (
    .ref_clk    (ref_clk),
    .rstn       (rstn),
    .line_in    (sda_in),
    .line_level (sda_lvl),
    .line_rise  (sda_rise),
    .line_fall  (sda_fall)
  );

  // Open drain: the data pin is only ever driven low.
  assign sda_out = 1'b0;

  // Address-select pins come from outside the clock domain.
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sel_meta_reg <= 2'h0;
      sel_sync_reg <= 2'h0;
    end
    else
    begin
      sel_meta_reg <= {addr_select_pin_high, addr_select_pin_low};
      sel_sync_reg <= sel_meta_reg;
    end
  end

  // Expected address bit for position idx counted from the most significant bit.
  function expected_bit;
    input [3:0] idx;
    input [1:0] sel;
    reg   [6:0] full;
    begin
      full         = {`VFC_FIXED_ADDR, sel};
      expected_bit = full[3'd6 - idx[2:0]];
    end
  endfunction

  // Applies a command code to the status register; unknown codes leave it as it is.
  function [7:0] apply_cmd;
    input [7:0] cmd;
    input [7:0] stat;
    begin
      apply_cmd = stat;
      case (cmd)
        `VFC_CMD_PWRDN:      apply_cmd[`VFC_BIT_PWRDN] = 1'b1; // RULE_16
        `VFC_CMD_WAKE:       apply_cmd[`VFC_BIT_PWRDN] = 1'b0; // RULE_16
        `VFC_CMD_COMPONENT:  apply_cmd[`VFC_BIT_COMPOSITE] = 1'b0; // RULE_18
        `VFC_CMD_COMPOSITE:  apply_cmd[`VFC_BIT_COMPOSITE] = 1'b1; // RULE_18
        `VFC_CMD_SYNC_INT:   apply_cmd[`VFC_BIT_EXT_SYNC] = 1'b0; // RULE_19
        `VFC_CMD_SYNC_EXT:   apply_cmd[`VFC_BIT_EXT_SYNC] = 1'b1; // RULE_19
        `VFC_CMD_POL_POS:    apply_cmd[`VFC_BIT_NEG_POL] = 1'b0; // RULE_19
        `VFC_CMD_POL_NEG:    apply_cmd[`VFC_BIT_NEG_POL] = 1'b1; // RULE_19
        `VFC_CMD_FILT_ON:    apply_cmd[`VFC_BIT_BYPASS] = 1'b0; // RULE_20
        `VFC_CMD_FILT_OFF:   apply_cmd[`VFC_BIT_BYPASS] = 1'b1; // RULE_20
        `VFC_CMD_SOFT_RESET: apply_cmd = `VFC_STAT_RESET; // RULE_21
        default:
        begin
          // Codes 02h..07h: bit 2 of the status is the first input, bit 0 the third.
          if ((cmd >= `VFC_CMD_CLAMP1_LO) && (cmd <= `VFC_CMD_CLAMP3_HI)) // RULE_17
            apply_cmd[`VFC_BIT_CLAMP1 - ((cmd[2:1] - 2'h1) & 2'h3)] = cmd[0]; // RULE_17
        end
      endcase
    end
  endfunction

  // START and STOP take priority over any bit event in the same cycle, so a
  // framing condition is never mistaken for a data bit.
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg     <= ST_IDLE;
      bit_cnt_reg   <= 4'h0;
      shift_reg     <= 8'h00;
      read_dir_reg  <= 1'b0;
      nxt_reg       <= NXT_NONE;
      rd_freq_reg   <= 1'b0;
      drive_low_reg <= 1'b0;
      sda_oe_n      <= 1'b1;
      status_out    <= `VFC_STAT_RESET; // RULE_25
      freq_out      <= `VFC_FREQ_RESET;
    end
    else
    begin
      sda_oe_n <= ~drive_low_reg;
      if (scl_lvl && sda_fall)
      begin
        // START or repeated START restarts address reception from any state.
        state_reg     <= ST_ADDR; // RULE_01 RULE_05
        bit_cnt_reg   <= 4'h0;
        drive_low_reg <= 1'b0;
      end
      else if (scl_lvl && sda_rise)
      begin
        // STOP drops the transfer but keeps the armed read register; an unfinished data byte is simply never applied.
        state_reg     <= ST_IDLE; // RULE_01 RULE_03 RULE_15
        drive_low_reg <= 1'b0;
        nxt_reg       <= NXT_NONE;
      end
      else
      begin
        case (state_reg)
          ST_IDLE:
          begin
            drive_low_reg <= 1'b0; // RULE_02
          end
          ST_ADDR:
          begin
            if (scl_rise)
            begin
              shift_reg <= {shift_reg[6:0], sda_lvl};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              if (bit_cnt_reg < 4'h7)
              begin
                if (sda_lvl != expected_bit(bit_cnt_reg, sel_sync_reg)) // RULE_10 RULE_11
                  state_reg <= ST_IDLE; // RULE_10 RULE_26
              end
              else
                read_dir_reg <= sda_lvl; // RULE_13
            end
            else if (scl_fall && bit_cnt_reg == 4'h8)
            begin
              drive_low_reg <= 1'b1; // RULE_08 RULE_06
              state_reg     <= ST_AACK;
            end
          end
          ST_AACK:
          begin
            if (scl_fall)
            begin
              bit_cnt_reg <= 4'h0;
              if (read_dir_reg)
              begin
                // A read sends the frequency if armed, else the status; a write releases the bus.
                shift_reg     <= rd_freq_reg ? freq_out : status_out; // RULE_24
                drive_low_reg <= ~(rd_freq_reg ? freq_out[7] : status_out[7]);
                state_reg     <= ST_TXD;
              end
              else
              begin
                drive_low_reg <= 1'b0; // RULE_13
                nxt_reg       <= NXT_CMD; // RULE_14
                state_reg     <= ST_RXD;
              end
            end
          end
          ST_RXD:
          begin
            if (scl_rise)
            begin
              shift_reg   <= {shift_reg[6:0], sda_lvl};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
            else if (scl_fall && bit_cnt_reg == 4'h8)
            begin
              drive_low_reg <= 1'b1; // RULE_08
              state_reg     <= ST_DACK;
              if (nxt_reg == NXT_CMD)
              begin
                status_out <= apply_cmd(shift_reg, status_out); // RULE_27
                nxt_reg    <= (shift_reg == `VFC_CMD_LOAD_FREQ) ? NXT_FREQ : NXT_CMD;
                if (shift_reg == `VFC_CMD_READ_STAT)
                  rd_freq_reg <= 1'b0; // RULE_22
                else if (shift_reg == `VFC_CMD_READ_FREQ)
                  rd_freq_reg <= 1'b1; // RULE_22
              end
              else if (nxt_reg == NXT_FREQ)
              begin
                freq_out <= shift_reg; // RULE_23
                nxt_reg  <= NXT_CMD;
              end
            end
          end
          ST_DACK:
          begin
            if (scl_fall)
            begin
              drive_low_reg <= 1'b0;
              bit_cnt_reg   <= 4'h0;
              state_reg     <= ST_RXD;
            end
          end
          ST_TXD:
          begin
            if (scl_fall)
            begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              shift_reg   <= {shift_reg[6:0], 1'b0};
              if (bit_cnt_reg == 4'h7)
              begin
                drive_low_reg <= 1'b0; // RULE_09
                state_reg     <= ST_TACK;
              end
              else
                drive_low_reg <= ~shift_reg[6];
            end
          end
          ST_TACK:
          begin
            // One byte only: after the master's acknowledge pulse the slave goes quiet.
            if (scl_fall)
              state_reg <= ST_IDLE; // RULE_24
          end
          default:
            state_reg <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // vfc_i2c_slave

/* File: hdl/vfc_line_sync.v */
// Two-stage synchroniser with edge detection for the serial clock and data lines.
module vfc_line_sync (
  ref_clk,
  rstn,
  line_in,
  line_level,
  line_rise,
  line_fall
);
  input  wire ref_clk;
  input  wire rstn;
  input  wire line_in;
  output wire line_level;
  output wire line_rise;
  output wire line_fall;

  reg meta_reg;
  reg sync_reg;
  reg last_reg;

  // Lines idle high, so the stages reset high to avoid a false edge.
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      last_reg <= 1'b1;
    end
    else
    begin
      meta_reg <= line_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign line_level = sync_reg;
  assign line_rise  = sync_reg & ~last_reg;
  assign line_fall  = ~sync_reg & last_reg;
endmodule // vfc_line_sync

/* File: hdl/vfc_map.vh */
// Constants of the video filter command slave: address, commands, reset values, bit positions.
`ifndef VFC_MAP_VH
`define VFC_MAP_VH
`define VFC_FIXED_ADDR      5'h12
`define VFC_CMD_PWRDN       8'h00
`define VFC_CMD_WAKE        8'h01
`define VFC_CMD_CLAMP1_LO   8'h02
`define VFC_CMD_CLAMP3_HI   8'h07
`define VFC_CMD_COMPONENT   8'h08
`define VFC_CMD_COMPOSITE   8'h09
`define VFC_CMD_SYNC_INT    8'h0a
`define VFC_CMD_SYNC_EXT    8'h0b
`define VFC_CMD_POL_POS     8'h0c
`define VFC_CMD_POL_NEG     8'h0d
`define VFC_CMD_FILT_ON     8'h0e
`define VFC_CMD_FILT_OFF    8'h0f
`define VFC_CMD_SOFT_RESET  8'h10
`define VFC_CMD_READ_STAT   8'h11
`define VFC_CMD_LOAD_FREQ   8'h12
`define VFC_CMD_READ_FREQ   8'h13
`define VFC_STAT_RESET      8'h03
`define VFC_FREQ_RESET      8'hff
`define VFC_BIT_COMPOSITE   7
`define VFC_BIT_EXT_SYNC    6
`define VFC_BIT_NEG_POL     5
`define VFC_BIT_PWRDN       4
`define VFC_BIT_BYPASS      3
`define VFC_BIT_CLAMP1      2
`endif

/* File: verification/vfc_bus_master.sv */
// Behavioural serial bus master: frames, bytes and acknowledges on the two lines.
module vfc_bus_master (
  input  wire logic ref_clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_drv
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // The long low phase lets the slave drop its acknowledge before the clock rises.
  task automatic start();
    sda_drv <= 1'b1;
    tick(6);
    scl <= 1'b1;
    tick(6);
    sda_drv <= 1'b0;
    tick(6);
    scl <= 1'b0;
    tick(3);
  endtask
  task automatic stop();
    sda_drv <= 1'b0;
    tick(3);
    scl <= 1'b1;
    tick(6);
    sda_drv <= 1'b1;
    tick(6);
  endtask
  task automatic bit_io(input logic b, output logic s);
    sda_drv <= b;
    tick(3);
    scl <= 1'b1;
    tick(5);
    s = sda_line;
    tick(1);
    scl <= 1'b0;
    tick(3);
  endtask
  task automatic wbyte(input logic [7:0] v, output logic ack_n);
    for (int i = 7; i >= 0; i--)
      bit_io(v[i], ack_n);
    bit_io(1'b1, ack_n);
  endtask
  task automatic rbyte(output logic [7:0] v, input logic m_ack_n, output logic s9);
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, v[i]);
    bit_io(m_ack_n, s9);
  endtask
endmodule // vfc_bus_master

/* File: verification/vfc_i2c_slave_monitor.sv */
// Concurrent checks on the ports of the video filter command slave.
module vfc_i2c_slave_monitor (
  input wire logic       ref_clk,
  input wire logic       rstn,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_n,
  input wire logic       addr_select_pin_high,
  input wire logic       addr_select_pin_low,
  input wire logic [7:0] status_out,
  input wire logic [7:0] freq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  a_drain_low: assert property (sda_out == 1'b0)
    else $error("data output not tied low");
  a_reset_values: assert property ($rose(rstn) |-> status_out == 8'h03 && freq_out == 8'hff)
    else $error("bad values after reset");
  a_ack_fall_low: assert property ($fell(sda_oe_n) |-> !scl_in)
    else $error("data pulled low while clock high");
  a_release_low: assert property ($rose(sda_oe_n) |-> !scl_in)
    else $error("data released while clock high");
  a_drive_bounded: assert property ($fell(sda_oe_n) |-> ##[1:150] $rose(sda_oe_n))
    else $error("data line held too long");
  a_stat_clock_low: assert property (!$stable(status_out) |-> !scl_in)
    else $error("status changed while clock high");
  a_freq_clock_low: assert property (!$stable(freq_out) |-> !scl_in)
    else $error("frequency changed while clock high");
  a_stat_with_ack: assert property (!$stable(status_out) |-> ##[0:6] !sda_oe_n)
    else $error("status changed without acknowledge");
  a_freq_with_ack: assert property (!$stable(freq_out) |-> ##[0:6] !sda_oe_n)
    else $error("frequency changed without acknowledge");
  a_stop_idle: assert property (scl_in && $rose(sda_in) |-> ##1 sda_oe_n [*8])
    else $error("data driven after stop");
endmodule // vfc_i2c_slave_monitor
bind vfc_i2c_slave vfc_i2c_slave_monitor u_mon (.ref_clk(ref_clk), .rstn(rstn),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .addr_select_pin_high(addr_select_pin_high), .addr_select_pin_low(addr_select_pin_low),
  .status_out(status_out), .freq_out(freq_out));

/* File: verification/vfc_i2c_slave_tb.sv */
// Self-checking bench of the video filter command slave driven through a bus master model.
module vfc_i2c_slave_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       ref_clk;
  logic       rstn;
  logic       pin_hi;
  logic       pin_lo;
  logic       sda_oe_n;
  logic       sda_out;
  wire        scl;
  wire        sda_drv;
  logic [7:0] status_out;
  logic [7:0] freq_out;
  logic [7:0] s_exp;
  logic [7:0] d;
  logic [7:0] c;
  logic       ack;
  int         n_mismatch;
  int         tests_run;
  logic [7:0] extra [4] = '{8'h09, 8'h0f, 8'h00, 8'h01};
  logic [7:0] bad [3] = '{8'h90, 8'h00, 8'hf0};
  // Pull-up on the data line: any party pulling low wins.
  wire        sda = sda_drv & (sda_oe_n | sda_out);
  vfc_i2c_slave DUT (.ref_clk(ref_clk), .rstn(rstn), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_select_pin_high(pin_hi),
    .addr_select_pin_low(pin_lo), .status_out(status_out), .freq_out(freq_out));
  vfc_bus_master BM (.ref_clk(ref_clk), .sda_line(sda), .scl(scl), .sda_drv(sda_drv));
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] nxt(input logic [7:0] s, input logic [7:0] k);
    case (k)
      8'h00, 8'h01: s[4] = ~k[0];
      8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07: s[3 - k[2:1]] = k[0];
      8'h08, 8'h09: s[7] = k[0];
      8'h0a, 8'h0b: s[6] = k[0];
      8'h0c, 8'h0d: s[5] = k[0];
      8'h0e, 8'h0f: s[3] = k[0];
      8'h10: s = 8'h03;
      default: ;
    endcase
    return s;
  endfunction
  task automatic wr(input logic [7:0] k, input logic fin);
    BM.start();
    BM.wbyte({5'h12, pin_hi, pin_lo, 1'b0}, ack);
    chk({7'h0, ack}, 8'h00);
    BM.wbyte(k, ack);
    chk({7'h0, ack}, 8'h00);
    if (fin)
      BM.stop();
  endtask
  task automatic rd(input logic [7:0] k, input logic [7:0] exp);
    wr(k, 1'b0);
    BM.start();
    BM.wbyte({5'h12, pin_hi, pin_lo, 1'b1}, ack);
    chk({7'h0, ack}, 8'h00);
    BM.rbyte(d, 1'b1, ack);
    BM.stop();
    chk(d, exp);
    chk({7'h0, ack}, 8'h01);
  endtask
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (80000) @(posedge ref_clk);
    n_mismatch++;
    conclude();
  end
  initial
  begin
    rstn = 1'b0;
    pin_hi = 1'b0;
    pin_lo = 1'b0;
    n_mismatch = 0;
    tests_run = 0;
    s_exp = 8'h03;
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    chk(status_out, 8'h03);
    chk(freq_out, 8'hff);
    repeat (4) @(posedge ref_clk);
    // Odd codes end with a stop, even ones run into a repeated start.
    for (c = 8'h00; c < 8'h15; c++)
    begin
      {pin_hi, pin_lo} <= c[2:1];
      @(posedge ref_clk);
      wr(c, c[0]);
      s_exp = nxt(s_exp, c);
      chk(status_out, s_exp);
    end
    BM.stop();
    chk(freq_out, 8'hff);
    foreach (extra[i])
    begin
      wr(extra[i], 1'b1);
      s_exp = nxt(s_exp, extra[i]);
      chk(status_out, s_exp);
    end
    wr(8'h12, 1'b0);
    BM.wbyte(8'h5a, ack);
    chk({7'h0, ack}, 8'h00);
    BM.stop();
    chk(freq_out, 8'h5a);
    rd(8'h13, 8'h5a);
    rd(8'h11, s_exp);
    // The master acknowledges the byte and clocks on: the slave must stay released.
    wr(8'h13, 1'b0);
    BM.start();
    BM.wbyte({5'h12, pin_hi, pin_lo, 1'b1}, ack);
    chk({7'h0, ack}, 8'h00);
    BM.rbyte(d, 1'b0, ack);
    chk(d, 8'h5a);
    BM.rbyte(d, 1'b1, ack);
    BM.stop();
    chk(d, 8'hff);
    BM.start();
    BM.wbyte({5'h12, pin_hi, pin_lo, 1'b0}, ack);
    BM.wbyte(8'h12, ack);
    repeat (4) BM.bit_io(1'b0, ack);
    BM.stop();
    chk(freq_out, 8'h5a);
    BM.start();
    BM.wbyte({5'h12, pin_hi, pin_lo, 1'b0}, ack);
    repeat (5) BM.bit_io(1'b0, ack);
    BM.stop();
    chk(status_out, s_exp);
    wr(8'h12, 1'b0);
    BM.wbyte(8'h3c, ack);
    chk({7'h0, ack}, 8'h00);
    BM.stop();
    chk(freq_out, 8'h3c);
    {pin_hi, pin_lo} <= 2'b11;
    @(posedge ref_clk);
    foreach (bad[i])
    begin
      BM.start();
      BM.wbyte(bad[i], ack);
      chk({7'h0, ack}, 8'h01);
      BM.wbyte(8'h0e, ack);
      chk({7'h0, ack}, 8'h01);
      BM.stop();
      chk(status_out, s_exp);
    end
    // After the refusals the master tries again with the right address.
    wr(8'h0e, 1'b1);
    s_exp = nxt(s_exp, 8'h0e);
    chk(status_out, s_exp);
    conclude();
  end
endmodule // vfc_i2c_slave_tb
